// ==== rtl/dscp_map_pkg.sv ====
package dscp_map_pkg;

  // ********************************************************
  // sizes
  // ********************************************************
  localparam int CODE_W = 6;                    // code point width
  localparam int PRIO_W = 3;                    // 802.1p priority width
  localparam int ENTRIES = 64;                  // one entry per code point
  localparam int PORTS_DEF = 8;                 // default ingress port count
  localparam int PORT_W_DEF = 3;                // default port index width
  localparam int CU_W = 2;                      // unused low bits of ds octet

  // ********************************************************
  // register map (byte addresses, 32-bit words)
  // ********************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;     // bit 0 global enable
  localparam logic [7:0] ADDR_PORT_EN = 8'h04;  // per-port enables
  localparam logic [7:0] ADDR_TABLE = 8'h08;    // index access: [13:8] code, [2:0] prio
  localparam logic [7:0] ADDR_STATUS = 8'h0c;   // frames remapped count
  localparam int CTRL_EN_BIT = 0;               // global enable position
  localparam int TBL_IDX_LSB = 8;               // code field position in table word
  localparam logic CTRL_EN_RST = 1'b0;          // classification off after reset
  localparam logic [31:0] PORT_EN_RST = 32'h0000_0000; // ports off after reset

endpackage

// ==== rtl/prio_table_mem.sv ====
`timescale 1ns/1ps
// 64 x 3 table with two registered read ports, reloads defaults on reset
module prio_table_mem
  import dscp_map_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [CODE_W-1:0] waddr_i,
  input wire logic [PRIO_W-1:0] wdata_i,
  input wire logic [CODE_W-1:0] laddr_i,
  output logic [PRIO_W-1:0] ldata_o,
  input wire logic [CODE_W-1:0] raddr_i,
  output logic [PRIO_W-1:0] rdata_o
);

  // ********************************************************
  // storage
  // ********************************************************
  logic [PRIO_W-1:0] mem_q [ENTRIES];  // flip-flop table so reset can reload it

  // each entry reloads its default group index on reset
  for (genvar g = 0; g < ENTRIES; g++) begin : g_ent
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        // group index is the top bits of the code, eight codes per group
        mem_q[g] <= PRIO_W'(g >> (CODE_W - PRIO_W));
      end else if (we_i && waddr_i == CODE_W'(g)) begin
        mem_q[g] <= wdata_i;
      end
    end
  end

  // registered read ports: lookup and bus readback
  always_ff @(posedge clk_i) begin
    ldata_o <= mem_q[laddr_i];
    rdata_o <= mem_q[raddr_i];
  end

endmodule

// ==== rtl/frame_prio_stage.sv ====
`timescale 1ns/1ps
// delays the frame's side info to line up with the table read
module frame_prio_stage
  import dscp_map_pkg::*;
#(
  parameter int PORT_W = PORT_W_DEF
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input wire logic ip_i,
  input wire logic [PORT_W-1:0] port_i,
  input wire logic [PRIO_W-1:0] prio_i,
  output logic valid_o,
  output logic ip_o,
  output logic [PORT_W-1:0] port_o,
  output logic [PRIO_W-1:0] prio_o
);

  // valid must reset; data fields are qualified by it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      ip_o <= 1'b0;
      port_o <= '0;
      prio_o <= '0;
    end else begin
      valid_o <= valid_i;
      ip_o <= ip_i;
      port_o <= port_i;
      prio_o <= prio_i;
    end
  end

endmodule

// ==== rtl/dscp_priority_mapper.sv ====
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
// ingress classifier: ds code point to 802.1p priority
module dscp_priority_mapper
  import dscp_map_pkg::*;
#(
  parameter int PORTS = PORTS_DEF,
  parameter int PORT_W = PORT_W_DEF
)(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // frame from parser
  input wire logic frm_valid_i,
  input wire logic frm_ip_i,
  input wire logic [7:0] frm_ds_i,
  input wire logic [PORT_W-1:0] frm_port_i,
  input wire logic [PRIO_W-1:0] frm_prio_i,
  // frame to queueing
  output logic out_valid_o,
  output logic [PRIO_W-1:0] out_prio_o,
  output logic [PORT_W-1:0] out_port_o,
  output logic [PRIO_W-1:0] out_prec_o,
  output logic out_mapped_o
);

  // ********************************************************
  // elaboration checks
  // ********************************************************
  if (PORTS < 1 || PORTS > 32) begin : g_bad_ports
    $error("PORTS must be 1..32");
  end
  if ((1 << PORT_W) < PORTS) begin : g_bad_pw
    $error("PORT_W too narrow for PORTS");
  end

  // ********************************************************
  // registers
  // ********************************************************
  logic en_q;                    // global classification enable
  logic [PORTS-1:0] port_en_q;   // per-port enables
  logic [31:0] map_cnt_q;        // frames whose priority came from the table
  logic ack_q;                   // bus acknowledge
  logic [31:0] rdat_q;           // registered read data
  logic [CODE_W-1:0] rd_idx_q;   // code of the table read

  // decode of a bus address, used by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  logic req;       // fresh request, not yet acked
  logic wr;        // write taking effect at this ack
  logic tbl_we;    // table write strobe
  assign req = cyc_i && stb_i && !ack_q;
  assign wr = req && we_i;
  assign tbl_we = wr && hit(adr_i, ADDR_TABLE) && sel_i[1] && sel_i[0];

  // ********************************************************
  // lookup path
  // ********************************************************
  logic [CODE_W-1:0] code;         // upper six bits of the ds octet
  logic [PRIO_W-1:0] tbl_prio;     // registered table output
  logic [PRIO_W-1:0] tbl_rd;       // bus readback
  logic [PRIO_W-1:0] prec_q;       // legacy precedence, aligned
  logic s_valid;
  logic s_ip;
  logic [PORT_W-1:0] s_port;
  logic [PRIO_W-1:0] s_prio;

  // low two unused bits are dropped
  assign code = frm_ds_i[7:CU_W];

  // software writes go straight into the table used by lookups
  prio_table_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(tbl_we),
    .waddr_i(dat_i[TBL_IDX_LSB +: CODE_W]),
    .wdata_i(dat_i[PRIO_W-1:0]),
    .laddr_i(code),
    .ldata_o(tbl_prio),
    .raddr_i(rd_idx_q),
    .rdata_o(tbl_rd)
  );

  frame_prio_stage #(.PORT_W(PORT_W)) u_stage (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .valid_i(frm_valid_i),
    .ip_i(frm_ip_i),
    .port_i(frm_port_i),
    .prio_i(frm_prio_i),
    .valid_o(s_valid),
    .ip_o(s_ip),
    .port_o(s_port),
    .prio_o(s_prio)
  );

  // precedence bits are the top three code bits, kept for consistency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prec_q <= '0;
    end else begin
      prec_q <= code[CODE_W-1 -: PRIO_W];
    end
  end

  logic use_map;  // frame takes the table priority
  assign use_map = en_q && s_ip && port_en_q[s_port];

  // output stage: table priority or the arrival priority
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_prio_o <= '0;
      out_port_o <= '0;
      out_prec_o <= '0;
      out_mapped_o <= 1'b0;
    end else begin
      out_valid_o <= s_valid;
      out_port_o <= s_port;
      out_prec_o <= prec_q;
      out_mapped_o <= s_valid && use_map;
      out_prio_o <= use_map ? tbl_prio : s_prio;
    end
  end

  // count remapped frames for software visibility
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      map_cnt_q <= '0;
    end else if (s_valid && use_map) begin
      map_cnt_q <= map_cnt_q + 32'h0000_0001;
    end
  end

  // ********************************************************
  // wishbone slave
  // ********************************************************
  // control writes, byte lane 0 only for the enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= CTRL_EN_RST;
      port_en_q <= PORT_EN_RST[PORTS-1:0];
    end else if (wr) begin
      if (hit(adr_i, ADDR_CTRL) && sel_i[0]) begin
        en_q <= dat_i[CTRL_EN_BIT];
      end
      if (hit(adr_i, ADDR_PORT_EN)) begin
        for (int b = 0; b < PORTS; b++) begin
          if (sel_i[b/8]) begin
            port_en_q[b] <= dat_i[b];
          end
        end
      end
    end
  end

  // ack one cycle after the request; table reads need an extra cycle
  // so the indexed entry has settled in the memory's read register
  logic tbl_wait_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      tbl_wait_q <= 1'b0;
      rd_idx_q <= '0;
      rdat_q <= '0;
    end else begin
      ack_q <= 1'b0;
      if (req && !we_i && hit(adr_i, ADDR_TABLE) && !tbl_wait_q) begin
        tbl_wait_q <= 1'b1;  // wait one cycle for the readback port
      end else if (req) begin
        tbl_wait_q <= 1'b0;
        ack_q <= 1'b1;
        case (adr_i)
          ADDR_CTRL: rdat_q <= {31'h0, en_q};
          ADDR_PORT_EN: rdat_q <= 32'(port_en_q);
          // index and entry merge here so the read data leave from a flop
          ADDR_TABLE: rdat_q <= (32'(rd_idx_q) << TBL_IDX_LSB) | 32'(tbl_rd);
          ADDR_STATUS: rdat_q <= map_cnt_q;
          default: rdat_q <= 32'h0000_0000;  // unmapped reads zero
        endcase
      end
      if (tbl_we) begin
        rd_idx_q <= dat_i[TBL_IDX_LSB +: CODE_W];  // select entry for readback
      end
    end
  end

  // read data and ack leave the block straight from their registers
  assign dat_o = rdat_q;
  assign ack_o = ack_q;

  // ********************************************************
  // assertions
  // ********************************************************
  property p_unmapped_bypass;
    @(posedge clk_i) disable iff (rst_i)
      (s_valid && (!en_q || !s_ip)) |=> (out_prio_o == $past(s_prio));
  endproperty
  a_unmapped_bypass: assert property (p_unmapped_bypass)
    else $error("bypass frame priority changed");

  property p_port_off;
    @(posedge clk_i) disable iff (rst_i)
      (s_valid && !port_en_q[s_port]) |=> !out_mapped_o;
  endproperty
  a_port_off: assert property (p_port_off)
    else $error("disabled port was remapped");

  property p_non_ip;
    @(posedge clk_i) disable iff (rst_i)
      (s_valid && !s_ip) |=> (!out_mapped_o && out_valid_o);
  endproperty
  a_non_ip: assert property (p_non_ip)
    else $error("non-ip frame remapped");

  property p_prec;
    @(posedge clk_i) disable iff (rst_i)
      frm_valid_i |=> ##1 (out_prec_o == $past(frm_ds_i[7:5], 2));
  endproperty
  a_prec: assert property (p_prec)
    else $error("precedence bits misaligned");

  sequence s_write_entry;
    tbl_we;
  endsequence
  // a lookup of the written code one cycle later must see the new value
  property p_new_entry;
    logic [CODE_W-1:0] idx;
    logic [PRIO_W-1:0] v;
    @(posedge clk_i) disable iff (rst_i)
      (s_write_entry, idx = dat_i[TBL_IDX_LSB +: CODE_W], v = dat_i[PRIO_W-1:0])
        ##1 (code == idx) |=> (tbl_prio == v);
  endproperty
  a_new_entry: assert property (p_new_entry)
    else $error("table write not seen");

  property p_mapped_prio;
    @(posedge clk_i) disable iff (rst_i)
      (s_valid && use_map) |=> (out_mapped_o && out_prio_o == $past(tbl_prio));
  endproperty
  a_mapped_prio: assert property (p_mapped_prio)
    else $error("mapped priority wrong");

  property p_default_table;
    @(posedge clk_i)
      $fell(rst_i) |-> (u_mem.mem_q[63] == 3'h7 && u_mem.mem_q[8] == 3'h1);
  endproperty
  a_default_table: assert property (p_default_table)
    else $error("default table not loaded");

  // the entry picked by the upper six octet bits is what a mapped frame gets
  property p_code_bits;
    @(posedge clk_i) disable iff (rst_i)
      frm_valid_i |-> ##2
        (!out_mapped_o || out_prio_o == $past(u_mem.mem_q[frm_ds_i[7:2]], 2));
  endproperty
  a_code_bits: assert property (p_code_bits)
    else $error("code point extraction wrong");

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held over two cycles");

  property p_write_ack;
    @(posedge clk_i) disable iff (rst_i)
      (req && we_i) |=> ack_o;
  endproperty
  a_write_ack: assert property (p_write_ack)
    else $error("write not acknowledged next cycle");

  // table reads take one wait cycle, then a single ack
  sequence s_tbl_read_req;
    req && !we_i && adr_i == ADDR_TABLE && !tbl_wait_q;
  endsequence
  sequence s_late_ack;
    !ack_o ##1 ack_o;
  endsequence
  property p_tbl_read_ack;
    @(posedge clk_i) disable iff (rst_i)
      s_tbl_read_req |=> s_late_ack;
  endproperty
  a_tbl_read_ack: assert property (p_tbl_read_ack)
    else $error("table read not acknowledged after one wait cycle");

  property p_frame_latency;
    @(posedge clk_i) disable iff (rst_i)
      frm_valid_i |-> ##2 out_valid_o;
  endproperty
  a_frame_latency: assert property (p_frame_latency)
    else $error("frame result not two cycles after arrival");

  property p_no_spurious;
    @(posedge clk_i) disable iff (rst_i)
      !frm_valid_i |-> ##2 !out_valid_o;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("result without an arriving frame");

  property p_port_carry;
    @(posedge clk_i) disable iff (rst_i)
      out_valid_o |-> (out_port_o == $past(frm_port_i, 2));
  endproperty
  a_port_carry: assert property (p_port_carry)
    else $error("ingress port not carried with the frame");

endmodule

// ==== bench/frame_parser_model.sv ====
`timescale 1ns/1ps
// parser side: one descriptor per cycle while send_i is high
module frame_parser_model
  import dscp_map_pkg::*;
(
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic ip_i,
  input wire logic [7:0] ds_i,
  input wire logic [2:0] port_i,
  input wire logic [PRIO_W-1:0] prio_i,
  output logic frm_valid_o,
  output logic frm_ip_o,
  output logic [7:0] frm_ds_o,
  output logic [2:0] frm_port_o,
  output logic [PRIO_W-1:0] frm_prio_o
);
  // ********************************************************
  // descriptor driver
  // ********************************************************
  initial begin
    {frm_valid_o, frm_ip_o, frm_ds_o, frm_port_o, frm_prio_o} = '0;
  end
  // fields toggle between descriptors so a stale value never passes for a fresh one
  always @(posedge clk_i) begin
    frm_valid_o <= send_i;
    if (send_i) begin
      {frm_ip_o, frm_ds_o, frm_port_o, frm_prio_o} <= {ip_i, ds_i, port_i, prio_i};
    end else begin
      {frm_ip_o, frm_ds_o, frm_port_o, frm_prio_o} <=
        ~{frm_ip_o, frm_ds_o, frm_port_o, frm_prio_o};
    end
  end
endmodule

// ==== bench/test_dscp_priority_mapper.sv ====
`timescale 1ns/1ps
module test_dscp_priority_mapper;
  import dscp_map_pkg::*;
  // ********************************************************
  // signals
  // ********************************************************
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic frm_valid_i, frm_ip_i, out_valid_o, out_mapped_o;
  logic [7:0] frm_ds_i;
  logic [2:0] frm_port_i, frm_prio_i, out_prio_o, out_port_o, out_prec_o;
  logic send, s_ip;       // requests to the parser model
  logic [7:0] s_ds;
  logic [2:0] s_port, s_prio;
  int errors, checks_done, mapped_n, i;
  typedef struct packed {logic ip; logic [7:0] ds; logic [2:0] port, pin, pout; logic map;} row_t;
  row_t rows [10];
  logic [9:0] got [$];    // results seen at the queueing side

  dscp_priority_mapper #(.PORTS(8), .PORT_W(3)) dscp_priority_mapper_inst (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .frm_valid_i(frm_valid_i),
    .frm_ip_i(frm_ip_i), .frm_ds_i(frm_ds_i), .frm_port_i(frm_port_i),
    .frm_prio_i(frm_prio_i), .out_valid_o(out_valid_o), .out_prio_o(out_prio_o),
    .out_port_o(out_port_o), .out_prec_o(out_prec_o), .out_mapped_o(out_mapped_o));
  frame_parser_model frame_parser_model_inst (.clk_i(clk_i), .send_i(send), .ip_i(s_ip),
    .ds_i(s_ds), .port_i(s_port), .prio_i(s_prio), .frm_valid_o(frm_valid_i),
    .frm_ip_o(frm_ip_i), .frm_ds_o(frm_ds_i), .frm_port_o(frm_port_i),
    .frm_prio_o(frm_prio_i));

  // ********************************************************
  // clock and monitor
  // ********************************************************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // out_valid is high for one cycle per frame, so each frame is caught on its own edge
  always @(posedge clk_i) begin
    if (out_valid_o === 1'b1) got.push_back({out_prio_o, out_port_o, out_prec_o, out_mapped_o});
  end

  // ********************************************************
  // tasks
  // ********************************************************
  task automatic close_out();
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; the slave's latency differs by register, so wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 10);
    if (ack_o !== 1'b1) begin
      errors++;
      close_out();
    end
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
    @(posedge clk_i);
  endtask
  task automatic send_frm(input logic ip, input logic [7:0] ds, input logic [2:0] pt, pr);
    @(posedge clk_i);
    {send, s_ip, s_ds, s_port, s_prio} <= {1'b1, ip, ds, pt, pr};
  endtask
  task automatic idle();
    @(posedge clk_i);
    send <= 1'b0;
  endtask
  task automatic expect_frm(input logic [2:0] p, pt, pr, input logic m);
    int n;
    n = 0;
    while (got.size() == 0 && n < 10) begin
      @(posedge clk_i);
      n++;
    end
    if (got.size() == 0) begin
      errors++;
      close_out();
    end
    check({22'h0, got[0]}, {22'h0, p, pt, pr, m});
    got.delete(0);
    if (m === 1'b1) mapped_n++;
  endtask
  task automatic one(input logic ip, input logic [7:0] ds, input logic [2:0] pt, pr, ep,
                     input logic em);
    send_frm(ip, ds, pt, pr);
    idle();
    expect_frm(ep, pt, ds[7:5], em);
  endtask

  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {1'b1, 47'h0};
    {send, s_ip, s_ds, s_port, s_prio} = '0;
    {errors, checks_done, mapped_n} = '0;
    // ip, ds octet, port, arrival prio, result prio, mapped
    rows = '{'{1, 8'h00, 0, 5, 0, 1}, '{1, 8'h1f, 1, 6, 0, 1}, '{1, 8'h20, 2, 7, 1, 1},
      '{1, 8'h5b, 3, 0, 2, 1}, '{1, 8'h7c, 4, 0, 3, 1}, '{1, 8'h83, 5, 0, 4, 1},
      '{1, 8'hb8, 6, 0, 5, 1}, '{1, 8'hc0, 7, 0, 6, 1}, '{1, 8'hfc, 7, 1, 7, 1},
      '{0, 8'hfc, 2, 3, 3, 0}};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, ADDR_CTRL, 32'h0, 4'hf);
    check(rd, 32'h0);
    wb(0, ADDR_PORT_EN, 32'h0, 4'hf);
    check(rd, 32'h0);
    one(1, 8'hfc, 2, 4, 4, 0);
    wb(1, ADDR_PORT_EN, 32'h0000_00ff, 4'hf);
    wb(1, ADDR_CTRL, 32'h1, 4'hf);
    // rows go back to back, results are matched in order afterwards
    for (i = 0; i < 10; i++) send_frm(rows[i].ip, rows[i].ds, rows[i].port, rows[i].pin);
    idle();
    for (i = 0; i < 10; i++)
      expect_frm(rows[i].pout, rows[i].port, rows[i].ds[7:5], rows[i].map);
    wb(1, ADDR_PORT_EN, 32'h0000_00f0, 4'hf);
    one(1, 8'hfc, 3, 1, 1, 0);
    one(1, 8'hfc, 4, 1, 7, 1);
    wb(1, ADDR_CTRL, 32'h0, 4'hf);
    one(1, 8'hfc, 4, 1, 1, 0);
    wb(1, ADDR_CTRL, 32'h1, 4'hf);
    wb(1, ADDR_TABLE, 32'h0000_3f01, 4'hf);
    wb(1, ADDR_TABLE, 32'h0000_0007, 4'hf);
    // a partial-lane write must leave the entry alone
    wb(1, ADDR_TABLE, 32'h0000_0002, 4'h1);
    wb(0, ADDR_TABLE, 32'h0, 4'hf);
    check({23'h0, rd[13:8], rd[2:0]}, {23'h0, 6'h00, 3'h7});
    one(1, 8'hfc, 5, 0, 1, 1);
    one(1, 8'h03, 6, 0, 7, 1);
    wb(0, ADDR_STATUS, 32'h0, 4'hf);
    check(rd, 32'(mapped_n));
    wb(1, 8'h10, 32'hffff_ffff, 4'hf);
    wb(0, 8'h10, 32'h0, 4'hf);
    check(rd, 32'h0);
    // second reset in mid-run must reload the default table
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, ADDR_STATUS, 32'h0, 4'hf);
    check(rd, 32'h0);
    wb(0, ADDR_CTRL, 32'h0, 4'hf);
    check(rd, 32'h0);
    // entry 0 held 7 before the reset; readback index is back at 0
    wb(0, ADDR_TABLE, 32'h0, 4'hf);
    check(rd, 32'h0);
    wb(1, ADDR_PORT_EN, 32'h0000_00ff, 4'hf);
    wb(1, ADDR_CTRL, 32'h1, 4'hf);
    one(1, 8'hfc, 5, 0, 7, 1);
    close_out();
  end
endmodule
